// ==== shared/pfc_pkg.sv ====
// constants and types shared by the forwarding core and its replay buffers
package pfc_pkg;

  // ****************************************
  // topology
  // ****************************************
  localparam int NPORT = 6;
  localparam int NVC = 2;
  localparam int NTC = 8;
  localparam int NLANE = 12;
  localparam int NREFCLK = 7;
  localparam int PW = 3;
  localparam int LTRW = 10;

  // lanes owned by each port, port 5 in the top slot
  localparam logic [NPORT-1:0][NLANE-1:0] PFC_PORT_LANES = {
    12'h800, 12'h400, 12'h200, 12'h100, 12'h0F0, 12'h00F
  };

  // route results: the upstream port 0, then drop and bridge beyond the real ports
  localparam logic [PW-1:0] PFC_DST_UP = 3'h0;
  localparam logic [PW-1:0] PFC_DST_DROP = 3'h6;
  localparam logic [PW-1:0] PFC_DST_BRIDGE = 3'h7;

  // ****************************************
  // timing
  // ****************************************
  localparam int PFC_CLK_PERIOD_PS = 4000;
  localparam int PFC_ISO_WINDOW_NS = 1024;
  localparam int PFC_ISO_WINDOW_CYC =
    (PFC_ISO_WINDOW_NS * 1000) / PFC_CLK_PERIOD_PS;

  // ****************************************
  // no-report latency value and obff reset value
  // ****************************************
  localparam logic [LTRW-1:0] PFC_LTR_NONE = 10'h3FF;
  localparam logic [1:0] PFC_OBFF_RESET = 2'h0;

  // ****************************************
  // types
  // ****************************************
  typedef enum logic [1:0] {
    PFC_POSTED, PFC_NONPOSTED, PFC_COMPLETION
  } pfc_kind_t;

  typedef enum logic [1:0] {
    PFC_L0, PFC_L0S, PFC_L1, PFC_L23_READY
  } pfc_link_pm_t;

  typedef enum logic [2:0] {
    PFC_D0, PFC_D1, PFC_D2, PFC_D3_HOT, PFC_D3_COLD
  } pfc_dev_pm_t;

  typedef struct packed {
    pfc_kind_t kind;
    logic route_id;
    logic relaxed;
    logic iso;
    logic translated;
    logic [2:0] tc;
    logic [31:0] addr;
    logic [15:0] dest_id;
    logic [15:0] req_id;
    logic [15:0] cpl_id;
    logic [9:0] len;
  } pfc_pkt_t;

  typedef struct packed {
    logic [15:0] bdf;
    logic [7:0] sec_bus;
    logic [7:0] sub_bus;
    logic [15:0] mem_base;
    logic [15:0] mem_limit;
    logic [NTC-1:0] tc_vc_map;
    logic vc1_en;
    logic acs_redirect;
    logic acs_direct_xlat;
    logic [7:0] iso_budget;
  } pfc_port_cfg_t;

endpackage

// ==== shared/pfc_egress_if.sv ====
// link between the forwarding core and one egress replay buffer
`timescale 1ns/100ps
interface pfc_egress_if;
  import pfc_pkg::*;
  logic push_valid;
  pfc_pkt_t push_pkt;
  logic space;
  logic empty;
  modport core (output push_valid, output push_pkt, input space,
                input empty);
  modport buffer (input push_valid, input push_pkt, output space,
                  output empty);
endinterface

// ==== logic/pfc_replay_buffer.sv ====
// egress replay buffer holding packets until the link partner acknowledges
`timescale 1ns/100ps
module pfc_replay_buffer
  import pfc_pkg::*;
#(
  parameter int DEPTH = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  pfc_egress_if.buffer eg,
  input wire logic tx_ready,
  input wire logic ack_valid,
  input wire logic nak_valid,
  output logic tx_valid,
  output pfc_pkt_t tx_pkt
);

  localparam int AW = $clog2(DEPTH);
  typedef logic [AW:0] pfc_ptr_t;

  typedef struct packed {
    pfc_pkt_t [DEPTH-1:0] mem;
    pfc_ptr_t wr;
    pfc_ptr_t snd;
    pfc_ptr_t ack;
    logic tx_valid;
    pfc_pkt_t tx_pkt;
  } pfc_rb_state_t;

  pfc_rb_state_t s_q;
  pfc_rb_state_t s_d;

  // ****************************************
  // occupancy
  // ****************************************
  assign eg.space = pfc_ptr_t'(s_q.wr - s_q.ack) != pfc_ptr_t'(DEPTH);
  assign eg.empty = (s_q.wr == s_q.ack) && !s_q.tx_valid;

  // ****************************************
  // store, send, retire and replay
  // ****************************************
  always_comb begin
    s_d = s_q;
    if (nak_valid) begin
      s_d.snd = s_q.ack;
      s_d.tx_valid = 1'b0;
    end else begin
      if (s_q.tx_valid && tx_ready) begin
        s_d.snd = s_q.snd + 1'b1;
        s_d.tx_valid = 1'b0;
      end else if (!s_q.tx_valid && s_q.snd != s_q.wr) begin
        s_d.tx_valid = 1'b1;
        s_d.tx_pkt = s_q.mem[s_q.snd[AW-1:0]];
      end
      if (ack_valid && s_q.ack != s_q.snd) begin
        s_d.ack = s_q.ack + 1'b1;
      end
    end
    if (eg.push_valid && eg.space) begin
      s_d.mem[s_q.wr[AW-1:0]] = eg.push_pkt;
      s_d.wr = s_q.wr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (!reset_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign tx_valid = s_q.tx_valid;
  assign tx_pkt = s_q.tx_pkt;

endmodule

// ==== logic/pfc_forwarding_core.sv ====
// six-port packet forwarding core with ingress queues and egress replay
// ****************************************
// Overview of operation
// - posted, non-posted and completion packets flow both ways at once.
// - after enumeration packets route by address or destination id.
// - packets are never split into pieces nor merged together.
// - requester and completer ids leave exactly as they arrived.
// - each port is a bridge with its own bus, device, function.
// - each ingress port queues packets per channel, drained by arbitration.
// - unordered packets may pass a blocked head when their egress is free.
// - ordered packets keep order across egress ports, accepting blocking.
// - every egress port holds packets in a replay buffer.
// - each ingress port counts and advertises its credits alone.
// - each port carries two virtual channels and eight traffic classes.
// - ingress maps classes to channels; egress arbitrates ports and channels.
// - isochronous packets need a nonzero class and use the second channel.
// - second channel wins; its port arbitration is time-budget policed.
// - unused second channel space is given to the first channel.
// - access control redirects peer traffic; translated may go direct.
// - low system reset returns all state to initial values.
// - per downstream port reset, low on system or software reset.
// - clock buffer power-down disables all reference clock outputs.
// - port 0 lanes 0-3, port 1 lanes 4-7, ports 2-5 lanes 8-11.
// - links support L0, L0s, L1, L2/L3 ready; device D0 to D3-cold.
// - latency tolerance and buffer flush/fill hints are reported.
// ****************************************
`timescale 1ns/100ps
module pfc_forwarding_core
  import pfc_pkg::*;
#(
  parameter int QDEPTH = 4,
  parameter int RDEPTH = 8,
  parameter int ISO_WINDOW_CYC = PFC_ISO_WINDOW_CYC
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic system_reset_n,
  input wire pfc_port_cfg_t [NPORT-1:0] port_cfg,
  input wire logic [NPORT-1:0] in_valid,
  input wire pfc_pkt_t [NPORT-1:0] in_pkt,
  output logic [NPORT-1:0][NVC-1:0][$clog2(2*QDEPTH):0] fc_credit,
  output logic [NPORT-1:0] tx_valid,
  output pfc_pkt_t [NPORT-1:0] tx_pkt,
  input wire logic [NPORT-1:0] tx_ready,
  input wire logic [NPORT-1:0] ack_valid,
  input wire logic [NPORT-1:0] nak_valid,
  output logic [NPORT-1:0] drop,
  output logic [NPORT-1:0] bridge_hit,
  input wire logic [NPORT-1:1] sw_downstream_reset,
  output logic [NPORT-1:1] downstream_port_reset_n,
  input wire logic clock_buffer_powerdown,
  output logic [NREFCLK-1:0] refclk_out_en,
  input wire logic [NPORT-1:0] port_link_up,
  output logic [NLANE-1:0] lane_enable,
  input wire pfc_link_pm_t [NPORT-1:0] link_pm_req,
  input wire pfc_dev_pm_t dev_pm_state,
  output pfc_link_pm_t [NPORT-1:0] link_pm_state,
  input wire logic [NPORT-1:1] ltr_valid,
  input wire logic [NPORT-1:1][LTRW-1:0] ltr_latency,
  output logic [LTRW-1:0] ltr_report,
  input wire logic [1:0] obff_in,
  output logic [NPORT-1:1][1:0] obff_out
);

  localparam int QSLOTS = 2 * QDEPTH;
  localparam int QAW = $clog2(QSLOTS);
  typedef logic [QAW-1:0] pfc_slot_t;
  typedef logic [QAW:0] pfc_cnt_t;

  typedef struct packed {
    pfc_pkt_t [NPORT-1:0][QSLOTS-1:0] mem;
    pfc_slot_t [NPORT-1:0][NVC-1:0] rd;
    pfc_slot_t [NPORT-1:0][NVC-1:0] wr;
    pfc_cnt_t [NPORT-1:0][NVC-1:0] cnt;
    pfc_cnt_t [NPORT-1:0][NVC-1:0] credit;
    logic [NPORT-1:0][PW-1:0] rr;
    logic [NPORT-1:0][7:0] iso_tok;
    logic [15:0] win_cnt;
    logic [NPORT-1:0] drop;
    logic [NPORT-1:0] bridge_hit;
    logic [NPORT-1:1] ds_rst_n;
    logic [NREFCLK-1:0] refclk_en;
    logic [NLANE-1:0] lane_en;
    pfc_link_pm_t [NPORT-1:0] pm;
    logic [LTRW-1:0] ltr;
    logic [NPORT-1:1][1:0] obff;
  } pfc_core_state_t;

  pfc_core_state_t s_q;
  pfc_core_state_t s_d;

  logic rst_n;
  logic [NPORT-1:0] eg_space;
  logic [NPORT-1:0] eg_empty;
  logic [NPORT-1:0] eg_ok;
  logic [NPORT-1:0] eg_pend;
  logic [NPORT-1:0] push_valid;
  pfc_pkt_t [NPORT-1:0] push_pkt;
  logic [NPORT-1:0][NVC-1:0] cand_valid;
  logic [NPORT-1:0][NVC-1:0] cand_next;
  logic [NPORT-1:0][NVC-1:0] taken;
  logic [NPORT-1:0][NVC-1:0] flush;
  logic [NPORT-1:0][NVC-1:0][PW-1:0] cand_dst;
  pfc_pkt_t [NPORT-1:0][NVC-1:0] cand_pkt;
  pfc_pkt_t hd;
  pfc_pkt_t nx;
  logic [PW-1:0] hdst;
  logic [PW-1:0] ndst;
  pfc_slot_t base;
  pfc_cnt_t sz;
  logic found;
  logic [PW-1:0] gp;
  logic gv;
  logic in_vc;
  int idx;
  pfc_link_pm_t want;

  // system reset joins the clock-domain reset
  assign rst_n = reset_n && system_reset_n;

  // ****************************************
  // helpers
  // ****************************************
  function automatic pfc_cnt_t vc_size(input int v, input logic en);
    if (en) begin
      return pfc_cnt_t'(QDEPTH);
    end
    return (v != 0) ? '0 : pfc_cnt_t'(QSLOTS);
  endfunction

  function automatic pfc_slot_t vc_base(input int v, input logic en);
    return (en && v != 0) ? pfc_slot_t'(QDEPTH) : '0;
  endfunction

  function automatic pfc_slot_t nxt(input pfc_slot_t i, input pfc_cnt_t n);
    return ({1'b0, i} + 1'b1 == n) ? '0 : i + 1'b1;
  endfunction

  function automatic logic [PW-1:0] route_of(input int src,
                                             input pfc_pkt_t p);
    logic by_id;
    logic hit;
    logic [PW-1:0] dst;
    by_id = p.route_id || p.kind == PFC_COMPLETION;
    dst = (src == 0) ? PFC_DST_DROP : PFC_DST_UP;
    for (int i = 1; i < NPORT; i++) begin
      if (by_id) begin
        hit = p.dest_id[15:8] >= port_cfg[i].sec_bus &&
              p.dest_id[15:8] <= port_cfg[i].sub_bus;
      end else begin
        hit = p.addr[31:16] >= port_cfg[i].mem_base &&
              p.addr[31:16] <= port_cfg[i].mem_limit;
      end
      if (hit) begin
        dst = PW'(i);
      end
    end
    if (src != 0 && dst == PW'(src)) begin
      dst = PFC_DST_DROP;
    end
    if (src != 0 && dst != PFC_DST_UP && dst != PFC_DST_DROP &&
        port_cfg[src].acs_redirect &&
        !(port_cfg[src].acs_direct_xlat && p.translated)) begin
      dst = PFC_DST_UP;
    end
    if (p.route_id && p.dest_id == port_cfg[src].bdf) begin
      dst = PFC_DST_BRIDGE;
    end
    return dst;
  endfunction

  // ****************************************
  // queues, arbitration and side controls
  // ****************************************
  always_comb begin
    s_d = s_q;
    s_d.drop = '0;
    s_d.bridge_hit = '0;
    push_valid = '0;
    push_pkt = '0;
    cand_valid = '0;
    cand_next = '0;
    cand_dst = '0;
    cand_pkt = '0;
    taken = '0;
    flush = '0;
    eg_pend = '0;
    hd = '0;
    nx = '0;
    hdst = '0;
    ndst = '0;
    base = '0;
    sz = '0;
    found = 1'b0;
    gp = '0;
    gv = 1'b0;
    in_vc = 1'b0;
    idx = 0;
    want = PFC_L0;
    for (int e = 0; e < NPORT; e++) begin
      eg_ok[e] = eg_space[e] && s_q.pm[e] == PFC_L0;
    end
    // head and next candidate of each ingress queue
    for (int p = 0; p < NPORT; p++) begin
      for (int v = 0; v < NVC; v++) begin
        base = vc_base(v, port_cfg[p].vc1_en);
        sz = vc_size(v, port_cfg[p].vc1_en);
        hd = s_q.mem[p][base + s_q.rd[p][v]];
        nx = s_q.mem[p][base + nxt(s_q.rd[p][v], sz)];
        hdst = route_of(p, hd);
        ndst = route_of(p, nx);
        if (s_q.cnt[p][v] != '0) begin
          if (hdst == PFC_DST_DROP || hdst == PFC_DST_BRIDGE) begin
            flush[p][v] = 1'b1;
            s_d.drop[p] = hdst == PFC_DST_DROP;
            s_d.bridge_hit[p] = hdst == PFC_DST_BRIDGE;
          end else if (eg_ok[hdst]) begin
            cand_valid[p][v] = 1'b1;
            cand_pkt[p][v] = hd;
            cand_dst[p][v] = hdst;
          end else begin
            eg_pend[hdst] = 1'b1;
            if (s_q.cnt[p][v] > pfc_cnt_t'(1) && nx.relaxed &&
                ndst != PFC_DST_DROP && ndst != PFC_DST_BRIDGE &&
                eg_ok[ndst]) begin
              cand_valid[p][v] = 1'b1;
              cand_next[p][v] = 1'b1;
              cand_pkt[p][v] = nx;
              cand_dst[p][v] = ndst;
            end
          end
        end
      end
    end
    // per egress: second channel first, round robin over ports
    for (int e = 0; e < NPORT; e++) begin
      found = 1'b0;
      for (int v = NVC - 1; v >= 0; v--) begin
        for (int k = 0; k < NPORT; k++) begin
          idx = int'(s_q.rr[e]) + k;
          if (idx >= NPORT) begin
            idx = idx - NPORT;
          end
          if (!found && cand_valid[idx][v] && cand_dst[idx][v] == PW'(e) &&
              (v == 0 || s_q.iso_tok[idx] != 8'h00)) begin
            found = 1'b1;
            gp = PW'(idx);
            gv = v[0];
          end
        end
      end
      if (found) begin
        push_valid[e] = 1'b1;
        push_pkt[e] = cand_pkt[gp][gv];
        taken[gp][gv] = 1'b1;
        s_d.rr[e] = (gp == PW'(NPORT - 1)) ? '0 : gp + 1'b1;
        if (gv) begin
          s_d.iso_tok[gp] = s_d.iso_tok[gp] - 8'h01;
        end
      end
    end
    // retire served heads, then accept new packets
    for (int p = 0; p < NPORT; p++) begin
      for (int v = 0; v < NVC; v++) begin
        base = vc_base(v, port_cfg[p].vc1_en);
        sz = vc_size(v, port_cfg[p].vc1_en);
        if (taken[p][v] || flush[p][v]) begin
          if (cand_next[p][v] && taken[p][v]) begin
            s_d.mem[p][base + nxt(s_q.rd[p][v], sz)] =
              s_q.mem[p][base + s_q.rd[p][v]];
          end
          s_d.rd[p][v] = nxt(s_q.rd[p][v], sz);
          s_d.cnt[p][v] = s_q.cnt[p][v] - 1'b1;
        end
      end
      in_vc = in_pkt[p].iso ||
              (in_pkt[p].tc != 3'h0 &&
               port_cfg[p].tc_vc_map[in_pkt[p].tc]);
      if (!port_cfg[p].vc1_en) begin
        in_vc = 1'b0;
      end
      base = vc_base(int'(in_vc), port_cfg[p].vc1_en);
      sz = vc_size(int'(in_vc), port_cfg[p].vc1_en);
      if (in_valid[p]) begin
        if ((in_pkt[p].iso && (in_pkt[p].tc == 3'h0 ||
             !port_cfg[p].vc1_en)) ||
            s_d.cnt[p][in_vc] >= sz) begin
          s_d.drop[p] = 1'b1;
        end else begin
          s_d.mem[p][base + s_q.wr[p][in_vc]] = in_pkt[p];
          s_d.wr[p][in_vc] = nxt(s_q.wr[p][in_vc], sz);
          s_d.cnt[p][in_vc] = s_d.cnt[p][in_vc] + 1'b1;
        end
      end
      for (int v = 0; v < NVC; v++) begin
        s_d.credit[p][v] = vc_size(v, port_cfg[p].vc1_en) -
                           s_d.cnt[p][v];
      end
    end
    // time window refills the second-channel budgets
    if (s_q.win_cnt == 16'h0000) begin
      s_d.win_cnt = 16'(ISO_WINDOW_CYC - 1);
      for (int p = 0; p < NPORT; p++) begin
        s_d.iso_tok[p] = port_cfg[p].iso_budget;
      end
    end else begin
      s_d.win_cnt = s_q.win_cnt - 16'h0001;
    end
    // link and device power
    for (int e = 0; e < NPORT; e++) begin
      unique case (dev_pm_state)
        PFC_D0: want = link_pm_req[e];
        PFC_D3_COLD: want = PFC_L23_READY;
        default: want = (link_pm_req[e] == PFC_L23_READY) ?
                        PFC_L23_READY : PFC_L1;
      endcase
      if (eg_pend[e] || cand_valid != '0 && want == PFC_L0) begin
        s_d.pm[e] = PFC_L0;
      end else if (eg_empty[e] && !eg_pend[e]) begin
        s_d.pm[e] = want;
      end
    end
    // lanes, clocks, resets, latency and flush hints
    s_d.lane_en = '0;
    for (int p = 0; p < NPORT; p++) begin
      if (port_link_up[p] && s_q.pm[p] != PFC_L23_READY) begin
        s_d.lane_en = s_d.lane_en | PFC_PORT_LANES[p];
      end
    end
    s_d.refclk_en = {NREFCLK{!clock_buffer_powerdown}};
    s_d.ds_rst_n = ~sw_downstream_reset;
    s_d.ltr = PFC_LTR_NONE;
    for (int p = 1; p < NPORT; p++) begin
      if (ltr_valid[p] && ltr_latency[p] < s_d.ltr) begin
        s_d.ltr = ltr_latency[p];
      end
      s_d.obff[p] = obff_in;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // ****************************************
  // egress replay buffers
  // ****************************************
  pfc_egress_if eg_if [NPORT] ();

  for (genvar e = 0; e < NPORT; e++) begin : g_egress
    assign eg_if[e].push_valid = push_valid[e];
    assign eg_if[e].push_pkt = push_pkt[e];
    assign eg_space[e] = eg_if[e].space;
    assign eg_empty[e] = eg_if[e].empty;
    pfc_replay_buffer #(
      .DEPTH(RDEPTH)
    ) u_replay (
      .clk(clk),
      .reset_n(rst_n),
      .eg(eg_if[e]),
      .tx_ready(tx_ready[e]),
      .ack_valid(ack_valid[e]),
      .nak_valid(nak_valid[e]),
      .tx_valid(tx_valid[e]),
      .tx_pkt(tx_pkt[e])
    );
  end

  // ****************************************
  // outputs
  // ****************************************
  assign fc_credit = s_q.credit;
  assign drop = s_q.drop;
  assign bridge_hit = s_q.bridge_hit;
  assign downstream_port_reset_n = s_q.ds_rst_n;
  assign refclk_out_en = s_q.refclk_en;
  assign lane_enable = s_q.lane_en;
  assign link_pm_state = s_q.pm;
  assign ltr_report = s_q.ltr;
  assign obff_out = s_q.obff;

endmodule

// ==== tb/pfc_core_props.sv ====
// assertion checker watching the forwarding core ports
`timescale 1ns/100ps
module pfc_core_props
  import pfc_pkg::*;
#(
  parameter int QDEPTH = 4
) (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic system_reset_n,
  input wire pfc_port_cfg_t [NPORT-1:0] port_cfg,
  input wire logic [NPORT-1:0] in_valid,
  input wire pfc_pkt_t [NPORT-1:0] in_pkt,
  input wire logic [NPORT-1:0][NVC-1:0][$clog2(2*QDEPTH):0] fc_credit,
  input wire logic [NPORT-1:0] tx_valid,
  input wire pfc_pkt_t [NPORT-1:0] tx_pkt,
  input wire logic [NPORT-1:0] tx_ready,
  input wire logic [NPORT-1:0] nak_valid,
  input wire logic [NPORT-1:0] drop,
  input wire logic [NPORT-1:1] sw_downstream_reset,
  input wire logic [NPORT-1:1] downstream_port_reset_n,
  input wire logic clock_buffer_powerdown,
  input wire logic [NREFCLK-1:0] refclk_out_en,
  input wire logic [NPORT-1:0] port_link_up,
  input wire logic [NLANE-1:0] lane_enable,
  input wire logic [1:0] obff_in,
  input wire logic [NPORT-1:1][1:0] obff_out
);
  // ****************************************
  // properties
  // ****************************************
  logic rst;
  assign rst = !reset_n || !system_reset_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_refclk;
    1'b1 |=> refclk_out_en == {NREFCLK{!$past(clock_buffer_powerdown)}};
  endproperty
  a_refclk: assert property (p_refclk) else $error("refclk enable wrong");
  property p_obff;
    1'b1 |=> obff_out == {(NPORT-1){$past(obff_in)}};
  endproperty
  a_obff: assert property (p_obff) else $error("obff copy wrong");
  property p_dsr;
    disable iff (!reset_n)
    (!system_reset_n || sw_downstream_reset[1])
      |=> !downstream_port_reset_n[1];
  endproperty
  a_dsr: assert property (p_dsr) else $error("port reset not low");
  property p_rst;
    disable iff (1'b0) rst |=> tx_valid == '0 && drop == '0;
  endproperty
  a_rst: assert property (p_rst) else $error("state kept in reset");
  property p_iso;
    in_valid[1] && in_pkt[1].iso && in_pkt[1].tc == 3'h0 |=> drop[1];
  endproperty
  a_iso: assert property (p_iso) else $error("iso on class 0 kept");
  property p_hold;
    tx_valid[3] && !tx_ready[3] && !nak_valid[3]
      |=> tx_valid[3] && $stable(tx_pkt[3]);
  endproperty
  a_hold: assert property (p_hold) else $error("egress packet changed");
  property p_bub;
    tx_valid[3] && tx_ready[3] |=> !tx_valid[3];
  endproperty
  a_bub: assert property (p_bub) else $error("no gap after send");
  property p_lane;
    (lane_enable[3:0] == 4'h0 || lane_enable[3:0] == 4'hF) &&
    (lane_enable[7:4] == 4'h0 || lane_enable[7:4] == 4'hF);
  endproperty
  a_lane: assert property (p_lane) else $error("wide port lanes split");
  property p_lane8;
    !$past(port_link_up[2]) |-> !lane_enable[8];
  endproperty
  a_lane8: assert property (p_lane8) else $error("lane 8 without link");
  property p_vc1;
    !port_cfg[2].vc1_en |-> fc_credit[2][1] == '0;
  endproperty
  a_vc1: assert property (p_vc1) else $error("credit on unused vc1");
endmodule

bind pfc_forwarding_core pfc_core_props #(.QDEPTH(QDEPTH)) i_pfc_core_props (
  .clk, .reset_n, .system_reset_n, .port_cfg, .in_valid, .in_pkt,
  .fc_credit, .tx_valid, .tx_pkt, .tx_ready, .nak_valid, .drop,
  .sw_downstream_reset, .downstream_port_reset_n, .clock_buffer_powerdown,
  .refclk_out_en, .port_link_up, .lane_enable, .obff_in, .obff_out
);

// ==== tb/pfc_link_model.sv ====
// link partner model taking egress packets and acknowledging them
`timescale 1ns/100ps
module pfc_link_model
  import pfc_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [NPORT-1:0] slow,
  input wire logic [NPORT-1:0] tx_valid,
  output logic [NPORT-1:0] tx_ready,
  output logic [NPORT-1:0] ack_valid
);
  logic [1:0] cnt_q;
  always_ff @(posedge clk) begin
    if (!reset_n) begin
      cnt_q <= 2'h0;
      tx_ready <= '0;
      ack_valid <= '0;
    end else begin
      cnt_q <= cnt_q + 2'h1;
      tx_ready <= ~slow | {NPORT{cnt_q == 2'h2}};
      ack_valid <= tx_valid & tx_ready;
    end
  end
endmodule

// ==== tb/tb_top.sv ====
// self-checking bench for the forwarding core
`timescale 1ns/100ps
module tb_top;
  import pfc_pkg::*;
  localparam int QD = 4;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic system_reset_n = 1'b0;
  pfc_port_cfg_t [NPORT-1:0] port_cfg;
  logic [NPORT-1:0] in_valid = '0;
  pfc_pkt_t [NPORT-1:0] in_pkt = '0;
  logic [NPORT-1:0][NVC-1:0][$clog2(2*QD):0] fc_credit;
  logic [NPORT-1:0] tx_valid, tx_ready, ack_valid, drop, bridge_hit;
  logic [NPORT-1:0] nak_valid = '0;
  pfc_pkt_t [NPORT-1:0] tx_pkt;
  logic [NPORT-1:1] sw_downstream_reset = '0;
  logic [NPORT-1:1] downstream_port_reset_n;
  logic clock_buffer_powerdown = 1'b0;
  logic [NREFCLK-1:0] refclk_out_en;
  logic [NPORT-1:0] port_link_up = '0;
  logic [NLANE-1:0] lane_enable;
  pfc_link_pm_t [NPORT-1:0] link_pm_req = '{default: PFC_L0};
  pfc_dev_pm_t dev_pm_state = PFC_D0;
  pfc_link_pm_t [NPORT-1:0] link_pm_state;
  logic [NPORT-1:1] ltr_valid = '0;
  logic [NPORT-1:1][LTRW-1:0] ltr_latency = '0;
  logic [LTRW-1:0] ltr_report;
  logic [1:0] obff_in = 2'h0;
  logic [NPORT-1:1][1:0] obff_out;
  logic [NPORT-1:0] slow = '0;
  int n_errors = 0;
  int compares = 0;

  always #2 clk = ~clk;

  pfc_forwarding_core #(.QDEPTH(QD), .ISO_WINDOW_CYC(16))
  i_pfc_forwarding_core (
    .clk, .reset_n, .system_reset_n, .port_cfg, .in_valid, .in_pkt,
    .fc_credit, .tx_valid, .tx_pkt, .tx_ready, .ack_valid, .nak_valid,
    .drop, .bridge_hit, .sw_downstream_reset, .downstream_port_reset_n,
    .clock_buffer_powerdown, .refclk_out_en, .port_link_up, .lane_enable,
    .link_pm_req, .dev_pm_state, .link_pm_state, .ltr_valid, .ltr_latency,
    .ltr_report, .obff_in, .obff_out
  );
  pfc_link_model i_pfc_link_model (
    .clk, .reset_n, .slow, .tx_valid, .tx_ready, .ack_valid
  );

  // ****************************************
  // helpers
  // ****************************************
  task automatic summarize();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task automatic chk_bits(logic [15:0] got, logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk_pkt(pfc_pkt_t got, pfc_pkt_t exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: packet %h", $time, got);
    end
  endtask
  function automatic pfc_pkt_t mk(pfc_kind_t k, logic r, logic iso,
                                  logic [2:0] tc, logic [31:0] a,
                                  logic [15:0] d);
    mk = '{k, r, 1'b0, iso, 1'b0, tc, a, d, 16'hA5C3, 16'h3C5A, 10'h011};
  endfunction
  task automatic wait_tx(int p, pfc_pkt_t exp);
    int i;
    for (i = 0; i < 100; i++) begin
      @(negedge clk);
      if (tx_valid[p] === 1'b1 && tx_ready[p] === 1'b1) break;
    end
    if (i == 100) begin
      n_errors++;
      $display("CHECK FAILED at %0t: no packet", $time);
      summarize();
    end else begin
      chk_pkt(tx_pkt[p], exp);
    end
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    repeat (3) @(negedge clk);
    chk_bits(16'(downstream_port_reset_n), 16'h0000);
    reset_n = 1'b1;
    system_reset_n = 1'b1;
    repeat (2) @(negedge clk);
    chk_bits(16'(downstream_port_reset_n), 16'h001F);
    chk_bits(16'(refclk_out_en), 16'h007F);
    chk_bits(16'(fc_credit[1][1]), 16'(QD));
    chk_bits(16'(fc_credit[2][0]), 16'(2 * QD));
  endtask
  task automatic t_forward();
    pfc_pkt_t a, b, c;
    a = mk(PFC_POSTED, 1'b0, 1'b0, 3'h0, 32'h3000_0040, 16'h0000);
    b = mk(PFC_POSTED, 1'b0, 1'b0, 3'h0, 32'h3000_0080, 16'h0000);
    c = mk(PFC_COMPLETION, 1'b1, 1'b0, 3'h0, 32'h0, 16'h0200);
    slow[3] = 1'b1;
    in_valid = 6'h29;
    in_pkt[0] = a;
    in_pkt[3] = c;
    in_pkt[5] = mk(PFC_POSTED, 1'b1, 1'b0, 3'h0, 32'h0, 16'h0128);
    @(negedge clk);
    chk_bits(16'(fc_credit[0][0]), 16'(QD - 1));
    chk_bits(16'(fc_credit[1][0]), 16'(QD));
    in_valid = 6'h01;
    in_pkt[0] = b;
    @(negedge clk);
    in_valid = '0;
    chk_bits(16'(bridge_hit), 16'h0020);
    fork
      begin
        wait_tx(3, a);
        wait_tx(3, b);
      end
      wait_tx(0, c);
    join
    slow[3] = 1'b0;
  endtask
  task automatic t_drop();
    pfc_pkt_t g;
    g = mk(PFC_POSTED, 1'b0, 1'b1, 3'h5, 32'h3000_0100, 16'h0000);
    in_valid = 6'h16;
    in_pkt[1] = mk(PFC_POSTED, 1'b0, 1'b1, 3'h0, 32'h3000_0000, 16'h0);
    in_pkt[2] = g;
    in_pkt[4] = g;
    @(negedge clk);
    in_valid = '0;
    chk_bits(16'(drop[1]), 16'h0001);
    chk_bits(16'(drop[2]), 16'h0001);
    chk_bits(16'(drop[4]), 16'h0000);
    wait_tx(3, g);
  endtask
  task automatic t_rst_out();
    sw_downstream_reset = 5'h04;
    @(negedge clk);
    chk_bits(16'(downstream_port_reset_n), 16'h001B);
    sw_downstream_reset = '0;
    system_reset_n = 1'b0;
    @(negedge clk);
    chk_bits(16'(downstream_port_reset_n), 16'h0000);
    chk_bits(16'(fc_credit[1][0]), 16'h0000);
    system_reset_n = 1'b1;
    repeat (2) @(negedge clk);
    chk_bits(16'(fc_credit[1][0]), 16'(QD));
  endtask
  task automatic t_misc();
    clock_buffer_powerdown = 1'b1;
    obff_in = 2'h2;
    port_link_up = 6'h12;
    ltr_valid = 5'h0A;
    ltr_latency[2] = 10'h120;
    ltr_latency[4] = 10'h080;
    repeat (3) @(negedge clk);
    chk_bits(16'(refclk_out_en), 16'h0000);
    chk_bits(16'(obff_out), 16'h02AA);
    chk_bits(16'(ltr_report), 16'h0080);
    chk_bits(16'(lane_enable), 16'h04F0);
    ltr_valid = '0;
    clock_buffer_powerdown = 1'b0;
    repeat (2) @(negedge clk);
    chk_bits(16'(ltr_report), 16'h03FF);
    chk_bits(16'(refclk_out_en), 16'h007F);
    dev_pm_state = PFC_D3_COLD;
    repeat (2) @(negedge clk);
    chk_bits(16'(link_pm_state), 16'h0FFF);
    chk_bits(16'(lane_enable), 16'h0000);
  endtask

  initial begin
    for (int p = 0; p < NPORT; p++) begin
      port_cfg[p] = '0;
      port_cfg[p].bdf = {8'h01, 5'(p), 3'h0};
      port_cfg[p].sec_bus = 8'(p * 16);
      port_cfg[p].sub_bus = 8'(p * 16 + 15);
      port_cfg[p].mem_base = 16'(p * 4096);
      port_cfg[p].mem_limit = 16'(p * 4096 + 4095);
      port_cfg[p].tc_vc_map = 8'hE0;
      port_cfg[p].vc1_en = (p != 2);
      port_cfg[p].iso_budget = 8'h04;
    end
    t_reset();
    t_forward();
    t_drop();
    t_rst_out();
    t_misc();
    summarize();
  end
endmodule
